// ==== core/oled_cmd_pkg.sv ====
// types shared by the command decoder and its users
// assumes the numeric values live in oled_cmd_regs.svh
package oled_cmd_pkg;

  typedef enum logic {ST_CMD, ST_PARAM} decode_state_t;

  typedef struct packed {
    logic       cs_n;
    logic       dc;
    logic       wr_n;
    logic       rd_n;
    logic       serial;
    logic [7:0] data;
  } host_pins_t;

  typedef struct packed {
    logic [7:0] contrast;
    logic [6:0] start_line;
    logic [6:0] mux_ratio;
    logic [6:0] display_offset;
    logic [2:0] switch_freq_select;
    logic       dcdc_enable;
    logic       display_on;
    logic       seg_remap;
    logic       entire_on;
    logic       reverse_video;
    logic       scan_reverse;
    logic [3:0] osc_trim;
    logic [3:0] clk_div_m1;
    logic [3:0] discharge_period;
    logic [3:0] precharge_period;
    logic [7:0] common_deselect_level;
    logic [7:0] segment_precharge_level;
    logic [3:0] segment_discharge_level;
  } settings_t;

endpackage : oled_cmd_pkg

// ==== core/oled_cmd_regs.svh ====
// command codes, power-on values and timing constants of the command decoder
// assumes inclusion by bare name from the decoder and its package users
`ifndef OLED_CMD_REGS_SVH
`define OLED_CMD_REGS_SVH

`define CMD_COL_LO_NIB      4'h0
`define CMD_COL_HI_NIB      4'h1
`define CMD_DISCH_NIB       4'h3
`define CMD_SCAN_NIB        4'hC
`define CMD_START_LINE      8'h40
`define CMD_CONTRAST        8'h81
`define CMD_SEG_REMAP_HI    7'h50
`define CMD_ENTIRE_ON_HI    7'h52
`define CMD_REVERSE_HI      7'h53
`define CMD_DISPLAY_HI      7'h57
`define CMD_MUX             8'hA8
`define CMD_DCDC            8'hAD
`define CMD_ROW             8'hB0
`define CMD_OFFSET          8'hD3
`define CMD_CLOCK           8'hD5
`define CMD_PERIOD          8'hD9
`define CMD_COM_DESELECT    8'hDB
`define CMD_SEG_PRECHARGE   8'hDC
`define CMD_RMW             8'hE0
`define CMD_END             8'hEE
`define DCDC_PARAM_NIB      4'h8

`define SCAN_DIR_BIT        3
`define STATUS_BUSY_BIT     7
`define STATUS_OFF_BIT      6
`define STATUS_LOW_ZERO     3'h0

`define POR_COL             8'h00
`define POR_ROW             7'h00
`define POR_START_LINE      7'h00
`define POR_CONTRAST        8'h80
`define POR_MUX             7'h5F
`define POR_DCDC_FREQ       3'h0
`define POR_DCDC_EN         1'b1
`define POR_OSC_TRIM        4'h5
`define POR_CLK_DIV         4'h0
`define POR_DIS_PERIOD      4'h2
`define POR_PRE_PERIOD      4'h2
`define POR_LEVEL           8'h35
`define POR_DISCH           4'h0
`define POR_OFFSET          7'h00

`define CLK_PERIOD_PS       5000
`define BUSY_TIME_NS        50

`endif

// ==== core/oled_display_ram.sv ====
// display ram: flip-flop storage indexed by row and column
// assumes writes on clk and combinational reads; out-of-range addresses write nothing, read zero
`timescale 1ns/1ps
module oled_display_ram #(
  parameter int ROWS = 96,
  parameter int COLS = 192
) (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [6:0] row,
  input  wire logic [7:0] col,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  localparam int DEPTH = ROWS * COLS;

  logic [7:0] mem [DEPTH];
  logic       in_range;
  int         idx;

  always_comb begin
    in_range = (int'(row) < ROWS) && (int'(col) < COLS);
    idx      = int'(row) * COLS + int'(col);
    rdata    = in_range ? mem[idx] : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (we && in_range) begin
      mem[idx] <= wdata;
    end
  end
endmodule : oled_display_ram

// ==== core/oled_driver_command_decoder.sv ====
// command decoder and display-ram access of a grayscale oled driver
// assumes host bus pins are asynchronous to clk and held stable across strobes
// Operation
// RULE_01: byte 3xH loads its low nibble as segment discharge level, default 0.
// RULE_02: after E0H reads keep the column, writes still increment; host ends with EEH.
// RULE_03: EEH leaves read-modify-write and restores the saved column.
// RULE_04: data write stores byte at row and column, then column plus one.
// RULE_05: status read gives busy on bit 7, display-off on bit 6, bits 2-0 zero.
// RULE_06: commands arriving while busy are ignored; host waits for busy low.
// RULE_07: status display bit is the inverse of the display on setting.
// RULE_08: data read returns ram and increments column; host does one dummy read.
// RULE_09: no display data read over the serial interface.
// RULE_10: 0xH loads column low nibble, 1xH column high nibble, both reset zero.
// RULE_11: 40H makes next byte the start line, default zero.
// RULE_12: 81H makes next byte the contrast, default 80H.
// RULE_13: bytes A0H to A7H: bit 0 sets remap, entire-on, reverse video.
// RULE_14: A8H makes next byte the multiplex ratio, default 5FH.
// RULE_15: ADH makes next 8xH byte the dc-dc frequency and enable, default 81H.
// RULE_16: AEH/AFH turn the display off/on, default off.
// RULE_17: B0H makes next byte's low seven bits the row address.
// RULE_18: Cx byte bit 3 selects reversed common scan, default forward.
// RULE_19: D3H makes next byte's low seven bits the display offset.
// RULE_20: D5H next byte: upper nibble oscillator trim, lower divide minus one.
// RULE_21: D9H next byte: upper discharge period, lower precharge period, default 22H.
// RULE_22: DBH and DCH next byte sets deselect and precharge levels, default 35H.
// RULE_23: the byte after a double-byte mode byte is its parameter, not a command.
`timescale 1ns/1ps
`include "oled_cmd_regs.svh"
module oled_driver_command_decoder #(
  parameter int ROWS         = 96,
  parameter int COLS         = 192,
  parameter int BUSY_TIME_NS = `BUSY_TIME_NS
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   cs_n_pin,
  input  wire logic                   data_command_select,
  input  wire logic                   wr_n_pin,
  input  wire logic                   rd_n_pin,
  input  wire logic                   serial_mode_pin,
  input  wire logic [7:0]             d_in_pin,
  output logic      [7:0]             d_out,
  output logic                        d_oe,
  output logic                        busy,
  output oled_cmd_pkg::settings_t     settings
);
  localparam int BUSY_CYC_I = (BUSY_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam logic [7:0] BUSY_CYC = 8'(BUSY_CYC_I < 1 ? 1 : BUSY_CYC_I);
  localparam int PW = $bits(oled_cmd_pkg::host_pins_t);

  function automatic logic is_double(input logic [7:0] b);
    is_double = (b == `CMD_START_LINE) || (b == `CMD_CONTRAST) || (b == `CMD_MUX) ||
                (b == `CMD_DCDC) || (b == `CMD_ROW) || (b == `CMD_OFFSET) ||
                (b == `CMD_CLOCK) || (b == `CMD_PERIOD) || (b == `CMD_COM_DESELECT) ||
                (b == `CMD_SEG_PRECHARGE);
  endfunction : is_double

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: two flops per bit, only the second stage is read
  oled_cmd_pkg::host_pins_t pins_raw;
  oled_cmd_pkg::host_pins_t pin_s;
  logic [PW-1:0]            meta_q;
  logic [PW-1:0]            sync_q;
  logic                     wr_prev_q;
  logic                     rd_prev_q;

  assign pins_raw = '{cs_n: cs_n_pin, dc: data_command_select, wr_n: wr_n_pin,
                      rd_n: rd_n_pin, serial: serial_mode_pin, data: d_in_pin};

  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          meta_q[gi] <= 1'b1;
          sync_q[gi] <= 1'b1;
        end else begin
          meta_q[gi] <= pins_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign pin_s = oled_cmd_pkg::host_pins_t'(sync_q);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
    end else begin
      wr_prev_q <= pin_s.wr_n;
      rd_prev_q <= pin_s.rd_n;
    end
  end

  // a write is taken on the rising strobe edge, when data is surely settled
  logic wr_evt;
  logic rd_evt;
  logic cmd_ok;
  assign wr_evt = !pin_s.cs_n && pin_s.wr_n && !wr_prev_q;
  assign rd_evt = !pin_s.cs_n && !pin_s.rd_n && rd_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // decoder state
  oled_cmd_pkg::decode_state_t state_q, state_d;
  oled_cmd_pkg::settings_t     set_q, set_d;
  logic [7:0] pend_q, pend_d;
  logic [7:0] col_q, col_d;
  logic [6:0] row_q, row_d;
  logic [7:0] saved_col_q, saved_col_d;
  logic       rmw_q, rmw_d;
  logic [7:0] latch_q, latch_d;
  logic [7:0] dout_q, dout_d;
  logic       oe_q, oe_d;
  logic       busy_q, busy_d;
  logic [7:0] busy_cnt_q, busy_cnt_d;
  logic       ram_we;
  logic [7:0] ram_rdata;
  logic [7:0] b;

  assign b = pin_s.data;
  assign cmd_ok = wr_evt && !pin_s.dc && !busy_q;

  always_comb begin
    state_d     = state_q;
    set_d       = set_q;
    pend_d      = pend_q;
    col_d       = col_q;
    row_d       = row_q;
    saved_col_d = saved_col_q;
    rmw_d       = rmw_q;
    latch_d     = latch_q;
    dout_d      = dout_q;
    oe_d        = oe_q;
    ram_we      = 1'b0;
    busy_cnt_d  = (busy_cnt_q != 8'h00) ? busy_cnt_q - 8'h01 : busy_cnt_q;
    busy_d      = (busy_cnt_d != 8'h00);
    if (cmd_ok) begin                                        // [RULE_06]
      busy_cnt_d = BUSY_CYC;
      busy_d     = 1'b1;
      if (state_q == oled_cmd_pkg::ST_PARAM) begin           // [RULE_23]
        state_d = oled_cmd_pkg::ST_CMD;
        case (pend_q)
          `CMD_START_LINE:    set_d.start_line = b[6:0];     // [RULE_11]
          `CMD_CONTRAST:      set_d.contrast = b;            // [RULE_12]
          `CMD_MUX:           set_d.mux_ratio = b[6:0];      // [RULE_14]
          `CMD_DCDC: begin
            if (b[7:4] == `DCDC_PARAM_NIB) begin             // [RULE_15]
              set_d.switch_freq_select = b[3:1];
              set_d.dcdc_enable        = b[0];
            end
          end
          `CMD_ROW:           row_d = b[6:0];                // [RULE_17]
          `CMD_OFFSET:        set_d.display_offset = b[6:0]; // [RULE_19]
          `CMD_CLOCK: begin                                  // [RULE_20]
            set_d.osc_trim   = b[7:4];
            set_d.clk_div_m1 = b[3:0];
          end
          `CMD_PERIOD: begin                                 // [RULE_21]
            set_d.discharge_period = b[7:4];
            set_d.precharge_period = b[3:0];
          end
          `CMD_COM_DESELECT:  set_d.common_deselect_level = b;   // [RULE_22]
          `CMD_SEG_PRECHARGE: set_d.segment_precharge_level = b; // [RULE_22]
          default: ;
        endcase
      end else if (is_double(b)) begin                       // [RULE_23]
        pend_d  = b;
        state_d = oled_cmd_pkg::ST_PARAM;
      end else begin
        case (b[7:4])
          `CMD_COL_LO_NIB: col_d[3:0] = b[3:0];              // [RULE_10]
          `CMD_COL_HI_NIB: col_d[7:4] = b[3:0];              // [RULE_10]
          `CMD_DISCH_NIB:  set_d.segment_discharge_level = b[3:0]; // [RULE_01]
          `CMD_SCAN_NIB:   set_d.scan_reverse = b[`SCAN_DIR_BIT];  // [RULE_18]
          default: begin
            case (b[7:1])
              `CMD_SEG_REMAP_HI: set_d.seg_remap = b[0];     // [RULE_13]
              `CMD_ENTIRE_ON_HI: set_d.entire_on = b[0];     // [RULE_13]
              `CMD_REVERSE_HI:   set_d.reverse_video = b[0]; // [RULE_13]
              `CMD_DISPLAY_HI:   set_d.display_on = b[0];    // [RULE_16]
              default: begin
                if (b == `CMD_RMW) begin                     // [RULE_02]
                  rmw_d       = 1'b1;
                  saved_col_d = col_q;
                end else if (b == `CMD_END && rmw_q) begin   // [RULE_03]
                  rmw_d = 1'b0;
                  col_d = saved_col_q;
                end
              end
            endcase
          end
        endcase
      end
    end
    if (wr_evt && pin_s.dc) begin                            // [RULE_04]
      ram_we = 1'b1;
      col_d  = col_q + 8'h01;
    end
    if (pin_s.cs_n || pin_s.rd_n) begin
      oe_d = 1'b0;
    end
    if (rd_evt && !pin_s.dc) begin                           // [RULE_05] [RULE_07]
      dout_d                   = 8'h00;
      dout_d[`STATUS_BUSY_BIT] = busy_q;
      dout_d[`STATUS_OFF_BIT]  = !set_q.display_on;
      dout_d[2:0]              = `STATUS_LOW_ZERO;
      oe_d                     = 1'b1;
    end
    // prefetch pipeline: each read hands out the previous fetch, hence the dummy read
    if (rd_evt && pin_s.dc && !pin_s.serial) begin           // [RULE_08] [RULE_09]
      dout_d  = latch_q;
      latch_d = ram_rdata;
      oe_d    = 1'b1;
      if (!rmw_q) begin                                      // [RULE_02]
        col_d = col_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q     <= oled_cmd_pkg::ST_CMD;
      set_q       <= '{contrast: `POR_CONTRAST, start_line: `POR_START_LINE,
                       mux_ratio: `POR_MUX, display_offset: `POR_OFFSET,
                       switch_freq_select: `POR_DCDC_FREQ, dcdc_enable: `POR_DCDC_EN,
                       display_on: 1'b0, seg_remap: 1'b0, entire_on: 1'b0,
                       reverse_video: 1'b0, scan_reverse: 1'b0,
                       osc_trim: `POR_OSC_TRIM, clk_div_m1: `POR_CLK_DIV,
                       discharge_period: `POR_DIS_PERIOD,
                       precharge_period: `POR_PRE_PERIOD,
                       common_deselect_level: `POR_LEVEL,
                       segment_precharge_level: `POR_LEVEL,
                       segment_discharge_level: `POR_DISCH};
      pend_q      <= 8'h00;
      col_q       <= `POR_COL;
      row_q       <= `POR_ROW;
      saved_col_q <= `POR_COL;
      rmw_q       <= 1'b0;
      latch_q     <= 8'h00;
      dout_q      <= 8'h00;
      oe_q        <= 1'b0;
      busy_q      <= 1'b1;
      busy_cnt_q  <= BUSY_CYC;
    end else begin
      state_q     <= state_d;
      set_q       <= set_d;
      pend_q      <= pend_d;
      col_q       <= col_d;
      row_q       <= row_d;
      saved_col_q <= saved_col_d;
      rmw_q       <= rmw_d;
      latch_q     <= latch_d;
      dout_q      <= dout_d;
      oe_q        <= oe_d;
      busy_q      <= busy_d;
      busy_cnt_q  <= busy_cnt_d;
    end
  end

  oled_display_ram #(
    .ROWS (ROWS),
    .COLS (COLS)
  ) u_ram (
    .clk   (clk),
    .we    (ram_we),
    .row   (row_q),
    .col   (col_q),
    .wdata (b),
    .rdata (ram_rdata)
  );

  assign d_out    = dout_q;
  assign d_oe     = oe_q;
  assign busy     = busy_q;
  assign settings = set_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_mode_byte;
    cmd_ok && state_q == oled_cmd_pkg::ST_CMD && is_double(b);
  endsequence
  sequence s_contrast_param;
    cmd_ok && state_q == oled_cmd_pkg::ST_PARAM && pend_q == `CMD_CONTRAST;
  endsequence

  busy_blocks_cmd_a: assert property (wr_evt && !pin_s.dc && busy_q |=> // [RULE_06]
    $stable(set_q) && $stable(state_q))
    else $error("command taken while busy");
  busy_after_cmd_a: assert property (cmd_ok |=> busy_q [*2])              // [RULE_06]
    else $error("busy not raised after command");
  status_format_a: assert property (rd_evt && !pin_s.dc |=> d_oe &&      // [RULE_05]
    d_out[7] == $past(busy_q) && d_out[2:0] == 3'h0)
    else $error("status byte malformed");
  status_off_bit_a: assert property (rd_evt && !pin_s.dc |=>             // [RULE_07]
    d_out[6] == !settings.display_on)
    else $error("status display bit not inverse of display on");
  data_write_inc_a: assert property (wr_evt && pin_s.dc |=>              // [RULE_04]
    col_q == $past(col_q) + 8'h01)
    else $error("column not incremented after data write");
  rmw_read_hold_a: assert property (rd_evt && pin_s.dc && rmw_q && !pin_s.serial |=> // [RULE_02]
    col_q == $past(col_q))
    else $error("column moved on read in read-modify-write");
  end_restore_a: assert property (cmd_ok && state_q == oled_cmd_pkg::ST_CMD && // [RULE_03]
    b == `CMD_END && rmw_q |=> !rmw_q && col_q == $past(saved_col_q))
    else $error("end did not restore column");
  serial_no_read_a: assert property (rd_evt && pin_s.dc && pin_s.serial |=> // [RULE_09]
    !d_oe && col_q == $past(col_q))
    else $error("display data read over serial");
  discharge_load_a: assert property (cmd_ok && state_q == oled_cmd_pkg::ST_CMD && // [RULE_01]
    b[7:4] == `CMD_DISCH_NIB |=> settings.segment_discharge_level == $past(b[3:0]))
    else $error("discharge level not loaded");
  param_next_a: assert property (s_mode_byte |=> state_q == oled_cmd_pkg::ST_PARAM) // [RULE_23]
    else $error("mode byte did not arm parameter");
  contrast_load_a: assert property (s_contrast_param |=>               // [RULE_12]
    settings.contrast == $past(b) && state_q == oled_cmd_pkg::ST_CMD)
    else $error("contrast not loaded from parameter");
  display_onoff_a: assert property (cmd_ok && state_q == oled_cmd_pkg::ST_CMD && // [RULE_16]
    b[7:1] == `CMD_DISPLAY_HI |=> settings.display_on == $past(b[0]))
    else $error("display on flag wrong");
endmodule : oled_driver_command_decoder

// ==== verif/oled_host_model.sv ====
// host processor model on the parallel strobe port of the command decoder
// assumes one caller at a time; every pin change lands just after a rising clk edge
`timescale 1ns/1ps
module oled_host_model (
  input  wire logic                 clk,
  input  wire logic [7:0]           d_out,
  input  wire logic                 d_oe,
  output oled_cmd_pkg::host_pins_t  pins
);
  ////////////////////////////////////////////////////////////
  initial begin
    pins = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
  end

  // data held four cycles past the rising strobe, so the synced copy is settled
  task automatic wr(input logic dc, input logic [7:0] b);
    @(posedge clk);
    pins.cs_n <= 1'b0;
    pins.dc   <= dc;
    pins.data <= b;
    pins.wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    pins.wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    pins.cs_n <= 1'b1;
    // released bus shows the inverse, not a friendly stale value
    pins.data <= ~b;
  endtask : wr

  // bounded look for the drive; seen stays low if the port never answers
  task automatic rd(input logic dc, output logic [7:0] d, output logic seen);
    @(posedge clk);
    pins.cs_n <= 1'b0;
    pins.dc   <= dc;
    pins.rd_n <= 1'b0;
    seen = 1'b0;
    d    = 8'h00;
    for (int i = 0; i < 10 && !seen; i++) begin
      @(posedge clk);
      if (d_oe === 1'b1) begin
        seen = 1'b1;
        d    = d_out;
      end
    end
    repeat (2) @(posedge clk);
    pins.rd_n <= 1'b1;
    pins.cs_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : rd

  task automatic mode(input logic s);
    @(posedge clk);
    pins.serial <= s;
  endtask : mode
endmodule : oled_host_model

// ==== verif/tb.sv ====
// self-checking bench of the command decoder, stimulus through the host model
// assumes default busy time and a ram that keeps every written byte
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
  logic                     clk;
  logic                     reset_n;
  logic [7:0]               d_out;
  logic                     d_oe;
  logic                     busy;
  oled_cmd_pkg::settings_t  settings;
  oled_cmd_pkg::settings_t  exp;
  oled_cmd_pkg::host_pins_t pins;
  logic [7:0]               rdat;
  logic                     seen;
  int                       bad_count;
  int                       check_count;

  oled_driver_command_decoder i_dut (
    .clk                 (clk),
    .reset_n             (reset_n),
    .cs_n_pin            (pins.cs_n),
    .data_command_select (pins.dc),
    .wr_n_pin            (pins.wr_n),
    .rd_n_pin            (pins.rd_n),
    .serial_mode_pin     (pins.serial),
    .d_in_pin            (pins.data),
    .d_out               (d_out),
    .d_oe                (d_oe),
    .busy                (busy),
    .settings            (settings)
  );

  oled_host_model i_host (
    .clk   (clk),
    .d_out (d_out),
    .d_oe  (d_oe),
    .pins  (pins)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmd(input logic [7:0] b);
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      report_and_stop();
    end else begin
      i_host.wr(1'b0, b);
    end
  endtask : cmd

  task automatic c2(input logic [7:0] m, input logic [7:0] p);
    cmd(m);
    cmd(p);
  endtask : c2

  task automatic ck_set();
    repeat (2) @(posedge clk);
    `CHK("settings", exp, settings)
  endtask : ck_set

  task automatic st(input logic [7:0] e);
    i_host.rd(1'b0, rdat, seen);
    `CHK("status enable", 1'b1, seen)
    `CHK("status", e, rdat)
  endtask : st

  task automatic rd_chk(input logic [7:0] e);
    i_host.rd(1'b1, rdat, seen);
    `CHK("read enable", 1'b1, seen)
    `CHK("read data", e, rdat)
  endtask : rd_chk
  ////////////////////////////////////////////////////////////
  initial begin
    reset_n     = 1'b0;
    bad_count   = 0;
    check_count = 0;
    exp = '{8'h80, 7'h00, 7'h5F, 7'h00, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
            4'h5, 4'h0, 4'h2, 4'h2, 8'h35, 8'h35, 4'h0};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    `CHK("busy after reset", 1'b1, busy)
    ck_set();
    cmd(8'hE3);
    // first status lands inside the busy window of the no-op, the second after it
    st(8'hC0);
    st(8'h40);
    i_host.wr(1'b1, 8'h77);
    // parameter byte that would also decode as display on
    c2(8'h81, 8'hAF);
    exp.contrast = 8'hAF;
    ck_set();
    c2(8'h40, 8'h3F);
    exp.start_line = 7'h3F;
    ck_set();
    c2(8'hA8, 8'h1F);
    exp.mux_ratio = 7'h1F;
    ck_set();
    c2(8'hAD, 8'h8A);
    exp.switch_freq_select = 3'h5;
    exp.dcdc_enable = 1'b0;
    ck_set();
    c2(8'hAD, 8'h3F);
    ck_set();
    c2(8'hD3, 8'h90);
    exp.display_offset = 7'h10;
    ck_set();
    c2(8'hD5, 8'hF3);
    exp.osc_trim = 4'hF;
    exp.clk_div_m1 = 4'h3;
    ck_set();
    c2(8'hD9, 8'h1F);
    exp.discharge_period = 4'h1;
    exp.precharge_period = 4'hF;
    ck_set();
    c2(8'hDB, 8'h00);
    c2(8'hDC, 8'hFF);
    exp.common_deselect_level = 8'h00;
    exp.segment_precharge_level = 8'hFF;
    ck_set();
    cmd(8'h3A);
    cmd(8'hCF);
    exp.segment_discharge_level = 4'hA;
    exp.scan_reverse = 1'b1;
    ck_set();
    cmd(8'hAF);
    st(8'h80);
    exp.display_on = 1'b1;
    cmd(8'hA5);
    // sent while still busy, must be dropped
    i_host.wr(1'b0, 8'hA1);
    exp.entire_on = 1'b1;
    ck_set();
    cmd(8'hA1);
    cmd(8'hA7);
    exp.seg_remap = 1'b1;
    exp.reverse_video = 1'b1;
    ck_set();
    cmd(8'hE3);
    st(8'h80);
    st(8'h00);
    c2(8'hB0, 8'h85);
    cmd(8'h02);
    cmd(8'h11);
    i_host.wr(1'b1, 8'hA5);
    i_host.wr(1'b1, 8'h5A);
    i_host.wr(1'b1, 8'hC3);
    cmd(8'h02);
    cmd(8'h11);
    i_host.rd(1'b1, rdat, seen);
    rd_chk(8'hA5);
    rd_chk(8'h5A);
    rd_chk(8'hC3);
    cmd(8'h02);
    cmd(8'h11);
    cmd(8'hE0);
    i_host.rd(1'b1, rdat, seen);
    rd_chk(8'hA5);
    rd_chk(8'hA5);
    i_host.wr(1'b1, 8'h11);
    i_host.wr(1'b1, 8'h22);
    cmd(8'hEE);
    i_host.mode(1'b1);
    i_host.rd(1'b1, rdat, seen);
    `CHK("serial read enable", 1'b0, seen)
    i_host.mode(1'b0);
    i_host.rd(1'b1, rdat, seen);
    rd_chk(8'h11);
    rd_chk(8'h22);
    c2(8'hB0, 8'h00);
    cmd(8'h00);
    cmd(8'h10);
    i_host.rd(1'b1, rdat, seen);
    rd_chk(8'h77);
    report_and_stop();
  end
endmodule : tb
